// ---- inc/swpm_pkg.sv ----
// Summary of operation
// RL1 - During a write the data bus is captured on rising edges of both the true and complementary input clocks, at a width of 8, 9, 18 or 36 bits.
// RL2 - The active-low write port select is sampled on the true clock rising edge, and a low value starts a write.
// RL3 - A write port select sampled high deselects the port and the data bus is ignored.
// RL4 - In the 8-bit configuration two active-low nibble selects mask bits 3 to 0 and bits 7 to 4, sampled on both clocks.
// RL5 - Each nibble select is sampled on the same edge as the data beat that it qualifies.
// RL6 - A nibble select sampled high keeps its four data bits of that beat out of the array.
// RL7 - In the 9, 18 and 36-bit configurations active-low byte selects mask 9-bit lanes, lane n covering bits 9n+8 to 9n.
// RL8 - A lane whose byte select is inactive during a beat leaves the array contents of that lane unchanged.
// RL9 - Each byte select is sampled on the same rising edge as its data word, on both clocks.
// RL10 - The address is sampled on the true clock rising edge that starts an operation.
// RL11 - The address is ignored at any sampling edge where the port select is inactive.
// RL12 - A write carries four beats for one address, alternating true and complementary edges over two periods, each with its own masks.
package swpm_pkg;

  localparam int SWPM_DATA_W_DEF = 36;
  localparam int SWPM_ADDR_W_DEF = 17;
  localparam int SWPM_NIBBLE_CFG_W = 8;
  localparam int SWPM_NIBBLE_W = 4;
  localparam int SWPM_LANE_W = 9;
  localparam int SWPM_NUM_NWS = 2;
  localparam int SWPM_NUM_BWS = 4;
  localparam int SWPM_BEAT_W = 2;
  localparam logic [1:0] SWPM_LAST_BEAT = 2'h3;
  localparam logic [1:0] SWPM_FIRST_BEAT = 2'h0;
  localparam int SWPM_SYNC_STAGES = 2;
  localparam int SWPM_BUF_DEPTH = 2;

  typedef enum logic [0:0] {
    SWPM_IDLE,
    SWPM_BURST
  } swpm_state_e;

endpackage : swpm_pkg

// ---- inc/swpm_beat_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// One captured write beat travelling from the capture logic into the buffer.
interface swpm_beat_if #(
  parameter int W = 8
);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : swpm_beat_if
`default_nettype wire

// ---- verilog/swpm_beat_buf.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two-entry buffer so that a one-beat stall by the array side loses nothing.
module swpm_beat_buf
  import swpm_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clock_in,
  input wire logic rst_in,
  swpm_beat_if.snk in_if,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);

  // The one-bit pointers serve exactly two entries, so no other depth is accepted.
  generate
    if (SWPM_BUF_DEPTH != 2 || W < 1)
    begin : g_bad_buf
      $error("The beat buffer needs a depth of two and a width of at least 1.");
    end
  endgenerate

  typedef struct packed {
    logic [SWPM_BUF_DEPTH-1:0][W-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } swpm_buf_s;

  swpm_buf_s s_q;
  swpm_buf_s s_d;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_if.ready = (s_q.cnt != 2'h2);
  assign out_valid_out = (s_q.cnt != 2'h0);
  assign out_data_out = s_q.mem[s_q.rp];
  assign push = in_if.valid && in_if.ready;
  assign pop = out_valid_out && out_ready_in;

  // Pointers wrap naturally because the depth is two.
  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.mem[s_q.wp] = in_if.data;
      s_d.wp = ~s_q.wp;
    end
    if (pop)
    begin
      s_d.rp = ~s_q.rp;
    end
    s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
  end

  // State register.
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule : swpm_beat_buf
`default_nettype wire

// ---- verilog/swpm_write_port.sv ----
`timescale 1ns/1ps
`default_nettype none
// Write-port front end: oversamples the input clock pins and captures four-beat writes.
module swpm_write_port
  import swpm_pkg::*;
#(
  parameter int DATA_W = SWPM_DATA_W_DEF,
  parameter int ADDR_W = SWPM_ADDR_W_DEF
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic kclk_in,
  input wire logic kclk_n_in,
  input wire logic write_port_select_n_in,
  input wire logic [SWPM_NUM_NWS-1:0] nibble_write_select_n_in,
  input wire logic [SWPM_NUM_BWS-1:0] byte_lane_write_select_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  output logic arr_valid_out,
  input wire logic arr_ready_in,
  output logic [ADDR_W-1:0] arr_addr_out,
  output logic [SWPM_BEAT_W-1:0] arr_beat_out,
  output logic [DATA_W-1:0] arr_data_out,
  output logic [DATA_W-1:0] arr_bit_we_out,
  output logic overrun_out
);

  // Only the documented widths have a lane layout.
  generate
    if (DATA_W != 8 && DATA_W != 9 && DATA_W != 18 && DATA_W != 36)
    begin : g_bad_width
      $error("DATA_W must be 8, 9, 18 or 36.");
    end
    if (ADDR_W < 1)
    begin : g_bad_addr
      $error("ADDR_W must be at least 1.");
    end
  endgenerate

  // Positions inside the synchronised pin vector.
  localparam int DATA_POS = 0;
  localparam int ADDR_POS = DATA_POS + DATA_W;
  localparam int BWS_POS = ADDR_POS + ADDR_W;
  localparam int NWS_POS = BWS_POS + SWPM_NUM_BWS;
  localparam int SEL_POS = NWS_POS + SWPM_NUM_NWS;
  localparam int KN_POS = SEL_POS + 1;
  localparam int K_POS = KN_POS + 1;
  localparam int PIN_W = K_POS + 1;
  localparam int PAY_W = ADDR_W + SWPM_BEAT_W + 2 * DATA_W;

  typedef struct packed {
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    logic k_prev;
    logic kn_prev;
    swpm_state_e st;
    logic [SWPM_BEAT_W-1:0] beat;
    logic [ADDR_W-1:0] addr;
    logic overrun;
  } swpm_core_s;

  swpm_core_s s_q;
  swpm_core_s s_d;
  logic [PIN_W-1:0] pins;
  logic k_rise;
  logic kn_rise;
  logic sel_n;
  logic [DATA_W-1:0] smp_data;
  logic [ADDR_W-1:0] smp_addr;
  logic [DATA_W-1:0] smp_we;
  logic start;
  logic [SWPM_BEAT_W-1:0] cur_beat;
  logic [ADDR_W-1:0] cur_addr;

  swpm_beat_if #(.W(PAY_W)) beat_if ();

  // Turns the sampled lane selects into one write enable per data bit.
  function automatic logic [DATA_W-1:0] lane_we(
    input logic [SWPM_NUM_NWS-1:0] nws_n,
    input logic [SWPM_NUM_BWS-1:0] bws_n
  );
    logic [DATA_W-1:0] we;
    we = '0;
    for (int i = 0; i < DATA_W; i++)
    begin
      if (DATA_W == SWPM_NIBBLE_CFG_W)
      begin
        we[i] = ~nws_n[i / SWPM_NIBBLE_W]; // [RL4] [RL6]
      end
      else
      begin
        we[i] = ~bws_n[i / SWPM_LANE_W]; // [RL7] [RL8]
      end
    end
    return we;
  endfunction : lane_we

  // Every pin is asynchronous to clock_in, so all of them share one two-stage
  // pipeline; clock, select, masks and data therefore stay aligned to the edge.
  assign pins = {kclk_in, kclk_n_in, write_port_select_n_in, nibble_write_select_n_in,
                 byte_lane_write_select_n_in, addr_in, wr_data_in};
  assign k_rise = s_q.sync2[K_POS] && !s_q.k_prev;
  assign kn_rise = s_q.sync2[KN_POS] && !s_q.kn_prev && !k_rise;
  assign sel_n = s_q.sync2[SEL_POS];
  assign smp_data = s_q.sync2[ADDR_POS-1:DATA_POS];
  assign smp_addr = s_q.sync2[BWS_POS-1:ADDR_POS];
  // Masks come from the same sample as the data, hence the same edge. [RL5] [RL9]
  assign smp_we = lane_we(s_q.sync2[SEL_POS-1:NWS_POS], s_q.sync2[NWS_POS-1:BWS_POS]);
  assign start = (s_q.st == SWPM_IDLE) && k_rise && !sel_n; // [RL2] [RL3]
  assign cur_addr = start ? smp_addr : s_q.addr; // [RL10] [RL11]
  assign beat_if.data = {cur_addr, cur_beat, smp_data, smp_we}; // [RL1]

  // Burst sequencer: beat 0 on the selecting true edge, then alternate edges.
  always_comb
  begin
    s_d = s_q;
    s_d.sync1 = pins;
    s_d.sync2 = s_q.sync1;
    s_d.k_prev = s_q.sync2[K_POS];
    s_d.kn_prev = s_q.sync2[KN_POS];
    beat_if.valid = 1'b0;
    cur_beat = s_q.beat;
    unique case (s_q.st)
      SWPM_IDLE:
      begin
        if (start)
        begin
          beat_if.valid = 1'b1;
          cur_beat = SWPM_FIRST_BEAT;
          s_d.addr = smp_addr; // [RL10]
          s_d.beat = SWPM_FIRST_BEAT + 2'h1;
          s_d.st = SWPM_BURST;
        end
      end
      SWPM_BURST:
      begin
        // Odd beats ride the complementary edge; the select is not looked at here.
        if (s_q.beat[0] ? kn_rise : k_rise) // [RL12]
        begin
          beat_if.valid = 1'b1;
          s_d.beat = s_q.beat + 2'h1;
          if (s_q.beat == SWPM_LAST_BEAT)
          begin
            s_d.st = SWPM_IDLE;
          end
        end
      end
    endcase
    // The pins cannot be stalled, so a beat refused by a full buffer is flagged.
    if (beat_if.valid && !beat_if.ready)
    begin
      s_d.overrun = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Buffer between capture and array.
  swpm_beat_buf #(
    .W(PAY_W)
  ) u_buf (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .in_if(beat_if.snk),
    .out_valid_out(arr_valid_out),
    .out_ready_in(arr_ready_in),
    .out_data_out({arr_addr_out, arr_beat_out, arr_data_out, arr_bit_we_out})
  );

  assign overrun_out = s_q.overrun;

  property p_start_beat;
    @(posedge clock_in) disable iff (rst_in)
    (s_q.st == SWPM_IDLE && k_rise && !sel_n) |-> beat_if.valid && cur_beat == 2'h0
      ##1 (s_q.st == SWPM_BURST && s_q.beat == 2'h1);
  endproperty
  a_start_beat: assert property (p_start_beat) else $error("Write not started."); // [RL2]

  property p_deselect;
    @(posedge clock_in) disable iff (rst_in)
    (s_q.st == SWPM_IDLE && sel_n) |-> !beat_if.valid ##1 s_q.st == SWPM_IDLE;
  endproperty
  a_deselect: assert property (p_deselect) else $error("Deselected port took data."); // [RL3]

  property p_data;
    @(posedge clock_in) disable iff (rst_in)
    beat_if.valid |-> beat_if.data[2*DATA_W-1:DATA_W] == s_q.sync2[ADDR_POS-1:DATA_POS];
  endproperty
  a_data: assert property (p_data) else $error("Beat data not from edge sample."); // [RL1]

  property p_lane0;
    @(posedge clock_in) disable iff (rst_in)
    (beat_if.valid && DATA_W != 8) |-> beat_if.data[SWPM_LANE_W-1:0]
      == {SWPM_LANE_W{~s_q.sync2[BWS_POS]}};
  endproperty
  a_lane0: assert property (p_lane0) else $error("Lane 0 enable wrong."); // [RL7] [RL9]

  property p_nibble;
    @(posedge clock_in) disable iff (rst_in)
    (beat_if.valid && DATA_W == 8) |-> beat_if.data[7:4] == {4{~s_q.sync2[NWS_POS+1]}}
      && beat_if.data[3:0] == {4{~s_q.sync2[NWS_POS]}};
  endproperty
  a_nibble: assert property (p_nibble) else $error("Nibble enable wrong."); // [RL4] [RL6]

  property p_addr_hold;
    @(posedge clock_in) disable iff (rst_in)
    (s_q.st == SWPM_BURST) |=> $stable(s_q.addr) || $past(s_q.beat) == 2'h3;
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("Address moved in burst."); // [RL11]

  property p_odd_edge;
    @(posedge clock_in) disable iff (rst_in)
    (beat_if.valid && cur_beat[0]) |-> kn_rise && !k_rise;
  endproperty
  a_odd_edge: assert property (p_odd_edge) else $error("Odd beat not on complement."); // [RL12]

  property p_end;
    @(posedge clock_in) disable iff (rst_in)
    (beat_if.valid && cur_beat == 2'h3) |=> s_q.st == SWPM_IDLE;
  endproperty
  a_end: assert property (p_end) else $error("Burst not closed after beat 3."); // [RL12]

  property p_overrun;
    @(posedge clock_in) disable iff (rst_in)
    (beat_if.valid && !beat_if.ready) |=> overrun_out;
  endproperty
  a_overrun: assert property (p_overrun) else $error("Lost beat not flagged."); // [RL8]

endmodule : swpm_write_port
`default_nettype wire

// ---- sim/swpm_ctl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host controller model: each pin value is held three clocks on both sides of its edge.
module swpm_ctl_model (
  input wire logic clock_in,
  output logic kclk_out,
  output logic kclk_n_out,
  output logic wsel_n_out,
  output logic [3:0] bws_n_out,
  output logic [16:0] addr_out,
  output logic [35:0] data_out
);
  // Idle levels; the clocks stand still between bursts.
  initial
  begin
    kclk_out = 1'b0;
    kclk_n_out = 1'b1;
    wsel_n_out = 1'b1;
    bws_n_out = 4'hF;
    addr_out = 17'h00000;
    data_out = 36'h000000000;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : tick

  // Four beats, select and address only with beat 0; released lines show inverse values.
  task automatic burst(input logic sel_n, input logic [16:0] a, input logic [3:0][35:0] d,
                       input logic [3:0][3:0] m);
    for (int b = 0; b < 4; b++)
    begin
      wsel_n_out = (b == 0) ? sel_n : 1'b1;
      addr_out = (b == 0) ? a : ~a;
      data_out = d[b];
      bws_n_out = m[b];
      tick(3);
      kclk_out = !b[0];
      kclk_n_out = b[0];
      tick(3);
    end
    data_out = ~d[3];
    bws_n_out = ~m[3];
  endtask : burst
endmodule : swpm_ctl_model
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rst, rdy, k, kn, wsel, v, ov, v8;
  logic [3:0] byte_lane_write_select_n;
  logic [16:0] addr, a_o;
  logic [35:0] data, d_o, we_o;
  logic [1:0] b_o;
  logic [7:0] d8, we8;
  int err_total, checks_done;

  swpm_ctl_model i_ctl (.clock_in(clk), .kclk_out(k), .kclk_n_out(kn), .wsel_n_out(wsel),
    .bws_n_out(byte_lane_write_select_n), .addr_out(addr), .data_out(data));
  swpm_write_port i_dut (.clock_in(clk), .rst_in(rst), .kclk_in(k), .kclk_n_in(kn),
    .write_port_select_n_in(wsel), .nibble_write_select_n_in(byte_lane_write_select_n[1:0]),
    .byte_lane_write_select_n_in(byte_lane_write_select_n), .addr_in(addr), .wr_data_in(data),
    .arr_valid_out(v), .arr_ready_in(rdy), .arr_addr_out(a_o), .arr_beat_out(b_o),
    .arr_data_out(d_o), .arr_bit_we_out(we_o), .overrun_out(ov));
  // The narrow instance shares the pins so the nibble masks see the same beats.
  swpm_write_port #(.DATA_W(8)) i_dut8 (.clock_in(clk), .rst_in(rst), .kclk_in(k),
    .kclk_n_in(kn), .write_port_select_n_in(wsel), .nibble_write_select_n_in(byte_lane_write_select_n[1:0]),
    .byte_lane_write_select_n_in(byte_lane_write_select_n), .addr_in(addr), .wr_data_in(data[7:0]),
    .arr_valid_out(v8), .arr_ready_in(rdy), .arr_addr_out(), .arr_beat_out(),
    .arr_data_out(d8), .arr_bit_we_out(we8), .overrun_out());

  // Clock generator at 20 MHz.
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [35:0] lw(input logic [3:0] m);
    return {{9{~m[3]}}, {9{~m[2]}}, {9{~m[1]}}, {9{~m[0]}}};
  endfunction : lw

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Waits for each of n beats, judges both instances, then lets the pop edge pass.
  task automatic rx(input logic [16:0] a, input logic [3:0][35:0] d,
                    input logic [3:0][3:0] m, input int n);
    for (int b = 0; b < n; b++)
    begin
      // With ready high a beat stands one cycle only, so it is looked at just after each edge.
      for (int i = 0; i < 40 && v !== 1'b1; i++)
      begin
        @(posedge clk);
        #1;
      end
      if (v !== 1'b1)
      begin
        chk(v, 1'b1);
        print_verdict();
      end
      chk(a_o, a);
      chk(b_o, b[1:0]);
      chk(we_o, lw(m[b]));
      chk(d_o & we_o, d[b] & lw(m[b]));
      chk({v8, we8}, {1'b1, {4{~m[b][1]}}, {4{~m[b][0]}}});
      chk(d8 & we8, d[b][7:0] & {{4{~m[b][1]}}, {4{~m[b][0]}}});
      @(posedge clk);
      #1;
    end
  endtask : rx

  task automatic t_burst();
    logic [3:0][35:0] d;
    for (int r = 0; r < 2; r++)
    begin
      for (int i = 0; i < 4; i++) d[i] = {9{4'(i + r * 4 + 1)}};
      fork
        i_ctl.burst(1'b0, 17'h10F0D + 17'(r), d, {4'h0, 4'hA, 4'h5, 4'hE});
        rx(17'h10F0D + 17'(r), d, {4'h0, 4'hA, 4'h5, 4'hE}, 4);
      join
    end
    $display("t_burst done");
  endtask : t_burst

  task automatic t_desel();
    fork
      i_ctl.burst(1'b1, 17'h0AAAA, {4{36'hF0F0F0F0F}}, '0);
      for (int i = 0; i < 30; i++)
      begin
        @(posedge clk);
        #1;
        if (v !== 1'b0) chk(v, 1'b0);
      end
    join
    chk(v, 1'b0);
    $display("t_desel done");
  endtask : t_desel

  task automatic t_stall();
    rdy = 1'b0;
    i_ctl.burst(1'b0, 17'h1FFFF, {36'hD, 36'hC, 36'hFFFFFFFFF, 36'h123456789}, '0);
    chk({v, ov}, 2'h3);
    rdy = 1'b1;
    rx(17'h1FFFF, {36'hD, 36'hC, 36'hFFFFFFFFF, 36'h123456789}, '0, 2);
    #1;
    chk(v, 1'b0);
    $display("t_stall done");
  endtask : t_stall

  // Main sequence.
  initial
  begin
    rst = 1'b1;
    rdy = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    chk({v, ov, v8}, 3'h0);
    t_burst();
    t_desel();
    t_stall();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
